// *** single_wire_uart_defs.svh ***
// Purpose: shared constants of the single-wire uart slave
// Assumes: included by bare name from the design files that use its macros
// Notes:   counts are in bit times unless the name says cycles
`ifndef SINGLE_WIRE_UART_DEFS_SVH
`define SINGLE_WIRE_UART_DEFS_SVH

// ==========================================================
// framing and datagram layout
`define SYNC_BYTE        8'h05
`define SYNC_PRESET      8'ha0
`define SYNC_KNOWN_BITS  4'h3
`define REPLY_ADDR       8'hff
`define RW_BIT           7
`define BYTE_BITS        4'h8
`define FRAME_LAST_BIT   4'h9
`define READ_LAST_IDX    3'h3
`define WRITE_LAST_IDX   3'h7
`define REPLY_LAST_IDX   3'h7
`define CRC_POLY         8'h07

// ==========================================================
// timing
`define GLITCH_CYCLES    16
`define TIMEOUT_BITS     8'h3f
`define RECOVER_BITS     8'h0c
`define TX_OFF_BITS      8'h04
`define DELAY_UNIT_BITS  8'h08

`endif

// *** single_wire_uart_pkg.sv ***
// Purpose: types of the single-wire uart slave
// Assumes: nothing
// Notes:   codes are written out so traces read the same in every tool
package single_wire_uart_pkg;

	// ==========================================================
	// receive and reply sequencer
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_START   = 4'h1,
		ST_MEASURE = 4'h2,
		ST_BITS    = 4'h3,
		ST_STOP    = 4'h4,
		ST_GAP     = 4'h5,
		ST_RECOVER = 4'h6,
		ST_TURN    = 4'h7,
		ST_TX      = 4'h8,
		ST_TXHOLD  = 4'h9
	} link_state_type;

endpackage

// *** line_sync.sv ***
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are quasi-static against ref_clk or single-bit lines
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module line_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             ref_clk,  // system clock
	input  wire logic             reset,    // synchronous, active high
	input  wire logic             clkEn,    // freezes state when low
	input  wire logic [WIDTH-1:0] asyncIn,  // raw pin levels
	output logic      [WIDTH-1:0] syncOut   // synchronised levels
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_q  <= RESET_VALUE;
			syncOut <= RESET_VALUE;
		end else if (clkEn) begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

// *** crc8_byte.sv ***
// Purpose: one byte step of the crc8 used on the single-wire link
// Assumes: bits enter least significant first
// Notes:   purely combinational; eight unrolled serial stages
`timescale 1ns/1ps
`include "single_wire_uart_defs.svh"

module crc8_byte (
	input  wire logic [7:0] crcIn,     // crc before this byte
	input  wire logic [7:0] dataByte,  // byte to fold in
	output logic      [7:0] crcOut     // crc after this byte
);

	logic [7:0] stage [0:8];

	assign stage[0] = crcIn;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			assign stage[i+1] = (stage[i][7] ^ dataByte[i]) ? ({stage[i][6:0], 1'b0} ^ `CRC_POLY)
			                                                : {stage[i][6:0], 1'b0};
		end
	endgenerate

	assign crcOut = stage[8];

endmodule

// *** single_wire_uart_slave.sv ***
// Purpose: single-wire half-duplex uart slave for register access
// Assumes: register file on ref_clk; readData valid in the cycle readStrobe is high
// Notes:   one shared line; the driver is enabled only for a read reply
`timescale 1ns/1ps
`include "single_wire_uart_defs.svh"

module single_wire_uart_slave
	import single_wire_uart_pkg::*;
#(
	parameter int                      PERIOD_WIDTH = 16,
	parameter logic [PERIOD_WIDTH-1:0] INIT_PERIOD  = '1
) (
	input  wire logic        ref_clk,                 // 250 MHz system clock
	input  wire logic        reset,                   // synchronous, active high
	input  wire logic        clkEn,                   // freezes all state when low
	input  wire logic        singleWireDataPinIn,     // shared data line level
	output logic             singleWireDataPinOut,    // level driven on the line
	output logic             singleWireDataPinOe,     // high while driving the line
	input  wire logic        addressStrapBit2,        // node offset +4
	input  wire logic        addressStrapBit1,        // node offset +2
	input  wire logic        addressStrapBit0,        // node offset +1
	input  wire logic [7:0]  nodeAddressBase,         // programmed base address
	input  wire logic [3:0]  replyTurnaroundDelay,    // reply delay setting
	input  wire logic        nextUnitSelect,          // programmed chain level
	output logic             chainEnableOutput,       // chain output pin
	output logic             writeStrobe,             // one-cycle accepted write
	output logic             readStrobe,              // one-cycle accepted read
	output logic [6:0]       regAddr,                 // register of last access
	output logic [31:0]      writeData,               // data of last write
	input  wire logic [31:0] readData,                // register contents for reply
	output logic [7:0]       datagramCount,           // accepted write count
	output logic             rxError                  // one-cycle error pulse
);

	localparam int MW = PERIOD_WIDTH + 2;

	generate
		if (PERIOD_WIDTH < 8 || PERIOD_WIDTH > 24) begin : g_bad_width
			$error("PERIOD_WIDTH must lie between 8 and 24");
		end
	endgenerate

	// ==========================================================
	// pins and address
	logic                    rxLine;
	logic                    rxPrev_q;
	logic                    fallEdge;
	logic [2:0]              straps;
	logic [7:0]              nodeAddr;

	line_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_data_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clkEn   (clkEn),
		.asyncIn (singleWireDataPinIn),
		.syncOut (rxLine)
	);

	line_sync #(.WIDTH(3), .RESET_VALUE(3'h0)) u_strap_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clkEn   (clkEn),
		.asyncIn ({addressStrapBit2, addressStrapBit1, addressStrapBit0}),
		.syncOut (straps)
	);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rxPrev_q <= 1'b1;
		end else if (clkEn) begin
			rxPrev_q <= rxLine;
		end
	end

	assign fallEdge = rxPrev_q & ~rxLine;
	assign nodeAddr = nodeAddressBase + {5'h00, straps};

	// ==========================================================
	// state
	link_state_type          state_q;
	link_state_type          prevState_q;
	logic                    settled;
	logic [MW-1:0]           cyc_q;
	logic [PERIOD_WIDTH-1:0] tgt_q;
	logic [PERIOD_WIDTH-1:0] period_q;
	logic [PERIOD_WIDTH-1:0] goodPeriod_q;
	logic                    goodValid_q;
	logic [PERIOD_WIDTH-1:0] refPeriod;
	logic [PERIOD_WIDTH-1:0] elCyc_q;
	logic [7:0]              elBits_q;
	logic                    timerRestart;
	logic [3:0]              bitCnt_q;
	logic                    falls_q;
	logic [2:0]              byteIdx_q;
	logic [7:0]              rxShift_q;
	logic [7:0]              crc_q;
	logic [7:0]              crcNext;
	logic [7:0]              dgram_q [0:7];
	logic                    sampleNow;
	logic                    bitEnd;
	logic                    finalByte;
	logic                    isWrite;
	logic                    addrOk;
	logic                    crcOk;
	logic                    acceptNow;
	logic [7:0]              turnBits;
	logic [2:0]              txIdx_q;
	logic [2:0]              txLoadIdx;
	logic [8:0]              txShift_q;
	logic [3:0]              txBit_q;
	logic [7:0]              txCrc_q;
	logic [7:0]              txCrcIn;
	logic [7:0]              txByte;
	logic [7:0]              txCrcNext;
	logic [31:0]             txData_q;

	assign settled   = (state_q == prevState_q);
	assign sampleNow = (cyc_q == {2'b00, tgt_q});
	assign bitEnd    = (cyc_q == {2'b00, period_q - 1'b1});
	assign isWrite   = dgram_q[2][`RW_BIT];
	assign finalByte = (byteIdx_q == `READ_LAST_IDX && !isWrite) || byteIdx_q == `WRITE_LAST_IDX;
	assign addrOk    = (dgram_q[1] == nodeAddr) && (nodeAddr != `REPLY_ADDR);
	assign crcOk     = (crc_q == rxShift_q);
	assign acceptNow = (state_q == ST_STOP) && sampleNow && rxLine && finalByte;
	assign turnBits  = 8'(({4'h0, replyTurnaroundDelay} + 8'h01) * `DELAY_UNIT_BITS);
	// timeouts use the last good datagram's rate, or period_q before one is seen; the reply keeps the request's rate
	assign refPeriod = (state_q == ST_TURN || state_q == ST_TX || state_q == ST_TXHOLD || !goodValid_q)
	                   ? period_q : goodPeriod_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prevState_q <= ST_IDLE;
		end else if (clkEn) begin
			prevState_q <= state_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q   <= ST_IDLE;
			cyc_q     <= '0;
			tgt_q     <= '0;
			bitCnt_q  <= 4'h0;
			falls_q   <= 1'b0;
			rxShift_q <= 8'h00;
			byteIdx_q <= 3'h0;
			period_q  <= INIT_PERIOD;
		end else if (clkEn) begin
			cyc_q <= cyc_q + 1'b1;
			case (state_q)
				ST_IDLE: begin
					if (fallEdge) begin
						state_q <= ST_START;
						cyc_q   <= {{(MW-1){1'b0}}, 1'b1};
					end
				end
				ST_START: begin
					if (rxLine) begin
						state_q <= ST_RECOVER;
					end else if (cyc_q == MW'(`GLITCH_CYCLES)) begin
						state_q <= ST_MEASURE;
						falls_q <= 1'b0;
					end
				end
				ST_MEASURE: begin
					if (&cyc_q) begin
						state_q <= ST_RECOVER;
					end else if (fallEdge && !falls_q) begin
						falls_q <= 1'b1;
					end else if (fallEdge) begin
						// start fall to sync bit 3 fall spans four bit times
						period_q  <= cyc_q[MW-1:2];
						tgt_q     <= {1'b0, cyc_q[MW-1:3]} - 1'b1;
						cyc_q     <= '0;
						bitCnt_q  <= `SYNC_KNOWN_BITS;
						rxShift_q <= `SYNC_PRESET;
						byteIdx_q <= 3'h0;
						state_q   <= ST_BITS;
					end
				end
				ST_BITS: begin
					if (sampleNow) begin
						cyc_q     <= '0;
						tgt_q     <= period_q - 1'b1;
						rxShift_q <= {rxLine, rxShift_q[7:1]};
						bitCnt_q  <= bitCnt_q + 1'b1;
						if (bitCnt_q == `BYTE_BITS - 1'b1) begin
							state_q <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (sampleNow) begin
						cyc_q <= '0;
						if (!rxLine) begin
							state_q <= ST_RECOVER;
						end else if (finalByte) begin
							// others' datagrams go back to idle, but a good crc still sets the good rate
							state_q <= !crcOk ? ST_RECOVER : (addrOk && !isWrite) ? ST_TURN : ST_IDLE;
						end else begin
							byteIdx_q <= byteIdx_q + 1'b1;
							state_q   <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					if (elBits_q > `TIMEOUT_BITS) begin
						state_q <= ST_RECOVER;
					end else if (fallEdge) begin
						state_q  <= ST_BITS;
						cyc_q    <= '0;
						bitCnt_q <= 4'h0;
						tgt_q    <= period_q + (period_q >> 1) - 1'b1;
					end
				end
				ST_RECOVER: begin
					if (settled && elBits_q >= `RECOVER_BITS) begin
						state_q <= ST_IDLE;
					end
				end
				ST_TURN: begin
					if (settled && elBits_q >= turnBits) begin
						state_q <= ST_TX;
						cyc_q   <= '0;
					end
				end
				ST_TX: begin
					if (bitEnd) begin
						cyc_q <= '0;
						if (txBit_q == `FRAME_LAST_BIT && txIdx_q == `REPLY_LAST_IDX) begin
							state_q <= ST_TXHOLD;
						end
					end
				end
				ST_TXHOLD: begin
					if (settled && elBits_q >= `TX_OFF_BITS) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// bit-time timer for gap, recovery, turnaround and release
	// idle recovery restarts on any low, so the line must stay idle throughout
	assign timerRestart = (fallEdge && (state_q == ST_IDLE || state_q == ST_GAP))
	                    || (state_q == ST_RECOVER && !rxLine)
	                    || (!settled && (state_q == ST_RECOVER || state_q == ST_TURN || state_q == ST_TXHOLD));

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			elCyc_q  <= '0;
			elBits_q <= 8'h00;
		end else if (clkEn) begin
			if (timerRestart) begin
				elCyc_q  <= '0;
				elBits_q <= 8'h00;
			end else if (elCyc_q >= refPeriod - 1'b1) begin
				elCyc_q <= '0;
				if (!(&elBits_q)) begin
					elBits_q <= elBits_q + 1'b1;
				end
			end else begin
				elCyc_q <= elCyc_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// datagram store and receive crc
	crc8_byte u_rx_crc (
		.crcIn    (crc_q),
		.dataByte (rxShift_q),
		.crcOut   (crcNext)
	);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			crc_q <= 8'h00;
		end else if (clkEn) begin
			if (state_q == ST_MEASURE) begin
				crc_q <= 8'h00;
			end else if (state_q == ST_STOP && sampleNow && rxLine && !finalByte) begin
				crc_q <= crcNext;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clkEn && state_q == ST_STOP && sampleNow && rxLine && !finalByte) begin
			dgram_q[byteIdx_q] <= rxShift_q;
		end
	end

	// ==========================================================
	// accepted accesses toward the register file
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			writeStrobe   <= 1'b0;
			readStrobe    <= 1'b0;
			regAddr       <= 7'h00;
			writeData     <= 32'h0000_0000;
			datagramCount <= 8'h00;
			goodPeriod_q  <= INIT_PERIOD;
			goodValid_q   <= 1'b0;
			rxError       <= 1'b0;
		end else if (clkEn) begin
			writeStrobe <= 1'b0;
			readStrobe  <= 1'b0;
			rxError     <= !settled && state_q == ST_RECOVER;
			if (acceptNow && crcOk) begin
				goodPeriod_q <= period_q;
				goodValid_q  <= 1'b1;
				if (addrOk) begin
					regAddr <= dgram_q[2][6:0];
					if (isWrite) begin
						writeStrobe   <= 1'b1;
						writeData     <= {dgram_q[3], dgram_q[4], dgram_q[5], dgram_q[6]};
						datagramCount <= datagramCount + 8'h01;
					end else begin
						readStrobe <= 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			chainEnableOutput <= 1'b1;
		end else if (clkEn) begin
			chainEnableOutput <= nextUnitSelect;
		end
	end

	// ==========================================================
	// read reply
	function automatic logic [7:0] replyByte(input logic [2:0] idx, input logic [6:0] addr,
	                                         input logic [31:0] data, input logic [7:0] crc);
		case (idx)
			3'h0:    replyByte = `SYNC_BYTE;
			3'h1:    replyByte = `REPLY_ADDR;
			3'h2:    replyByte = {1'b0, addr};
			3'h3:    replyByte = data[31:24];
			3'h4:    replyByte = data[23:16];
			3'h5:    replyByte = data[15:8];
			3'h6:    replyByte = data[7:0];
			default: replyByte = crc;
		endcase
	endfunction

	assign txLoadIdx = (state_q == ST_TURN) ? 3'h0 : txIdx_q + 3'h1;
	assign txCrcIn   = (state_q == ST_TURN) ? 8'h00 : txCrc_q;
	assign txByte    = replyByte(txLoadIdx, regAddr, txData_q, txCrc_q);

	crc8_byte u_tx_crc (
		.crcIn    (txCrcIn),
		.dataByte (txByte),
		.crcOut   (txCrcNext)
	);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			singleWireDataPinOut <= 1'b1;
			singleWireDataPinOe  <= 1'b0;
			txIdx_q              <= 3'h0;
			txShift_q            <= 9'h1ff;
			txBit_q              <= 4'h0;
			txCrc_q              <= 8'h00;
			txData_q             <= 32'h0000_0000;
		end else if (clkEn) begin
			if (readStrobe) begin
				txData_q <= readData;
			end
			if (state_q == ST_TURN && settled && elBits_q >= turnBits) begin
				singleWireDataPinOe  <= 1'b1;
				singleWireDataPinOut <= 1'b0;
				txShift_q            <= {1'b1, txByte};
				txBit_q              <= 4'h0;
				txIdx_q              <= 3'h0;
				txCrc_q              <= txCrcNext;
			end else if (state_q == ST_TX && bitEnd) begin
				if (txBit_q < `FRAME_LAST_BIT) begin
					singleWireDataPinOut <= txShift_q[0];
					txShift_q            <= {1'b1, txShift_q[8:1]};
					txBit_q              <= txBit_q + 1'b1;
				end else if (txIdx_q != `REPLY_LAST_IDX) begin
					singleWireDataPinOut <= 1'b0;
					txShift_q            <= {1'b1, txByte};
					txBit_q              <= 4'h0;
					txIdx_q              <= txLoadIdx;
					txCrc_q              <= txCrcNext;
				end
			end else if (state_q == ST_TXHOLD && settled && elBits_q >= `TX_OFF_BITS) begin
				singleWireDataPinOe <= 1'b0;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset || !clkEn);

	sequence finalStop;
		acceptNow;
	endsequence

	oe_only_reply_a: assert property (singleWireDataPinOe |-> state_q inside {ST_TX, ST_TXHOLD})
		else $error("line driven outside a reply");
	start_bit_low_a: assert property ($rose(singleWireDataPinOe) |-> !singleWireDataPinOut)
		else $error("reply does not open with a low start bit");
	count_step_a: assert property (writeStrobe |-> datagramCount == $past(datagramCount) + 8'h01)
		else $error("write did not advance the datagram count");
	read_count_a: assert property (readStrobe |-> $stable(datagramCount))
		else $error("read changed the datagram count");
	chain_reset_a: assert property ($past(reset) |-> chainEnableOutput)
		else $error("chain output not high after reset");
	glitch_recover_a: assert property (state_q == ST_START && rxLine |=> state_q == ST_RECOVER)
		else $error("short pulse not treated as a glitch");
	crc_reject_a: assert property (finalStop ##0 !crcOk |=> state_q == ST_RECOVER && !writeStrobe && !readStrobe)
		else $error("bad crc datagram not rejected");
	own_addr_a: assert property (writeStrobe || readStrobe |-> $past(addrOk) && $past(nodeAddr) != `REPLY_ADDR)
		else $error("access accepted for a foreign address");
	gap_timeout_a: assert property (state_q == ST_GAP && elBits_q > `TIMEOUT_BITS |=> state_q == ST_RECOVER)
		else $error("byte gap timeout missed");
	release_high_a: assert property ($fell(singleWireDataPinOe) |-> $past(singleWireDataPinOut) && state_q == ST_IDLE)
		else $error("driver released badly");
	turn_quiet_a: assert property (readStrobe |=> state_q == ST_TURN ##1 !singleWireDataPinOe)
		else $error("reply not held back for the turnaround");

endmodule

// *** host_uart_model.sv ***
// Purpose: host uart model on the shared single-wire line
// Assumes: fixed host rate of BIT ref_clk cycles per bit
// Notes:   changes its level at falling edges only; idles high
`timescale 1ns/1ps

module host_uart_model #(
	parameter int BIT = 64
) (
	input  wire logic ref_clk,   // system clock
	input  wire logic lineLevel, // resolved line level
	output logic      hostOut    // host transmit level
);
	// ==========================================================
	// bit timing and crc
	initial hostOut = 1'b1;

	task automatic bits(input int n);
		repeat (n * BIT) @(negedge ref_clk);
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		for (int j = 0; j < 8; j++) begin
			c = (c[7] ^ b[0]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
			b = b >> 1;
		end
		return c;
	endfunction

	// ==========================================================
	// transmit
	task automatic send_byte(input logic [7:0] b);
		hostOut = 1'b0;
		bits(1);
		for (int i = 0; i < 8; i++) begin
			hostOut = b[i];
			bits(1);
		end
		hostOut = 1'b1;
		bits(1);
	endtask

	task automatic pulse_low(input int n);
		hostOut = 1'b0;
		repeat (n) @(negedge ref_clk);
		hostOut = 1'b1;
	endtask

	task automatic send_dg(input logic [7:0] d [8], input int n, input bit bad);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n - 1; i++) begin
			send_byte(d[i]);
			c = crc8(c, d[i]);
		end
		send_byte(bad ? ~c : c);
	endtask

	// ==========================================================
	// receive; a missing start bit gives up after a bounded wait
	task automatic recv_byte(output logic [7:0] b, output bit ok);
		int k;
		k = 0;
		while (lineLevel !== 1'b0 && k < 40 * BIT) begin
			@(negedge ref_clk);
			k++;
		end
		repeat (BIT / 2) @(negedge ref_clk);
		ok = (lineLevel === 1'b0);
		for (int i = 0; i < 8; i++) begin
			bits(1);
			b[i] = lineLevel;
		end
		bits(1);
		ok = ok && (lineLevel === 1'b1);
	endtask
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the single-wire uart slave
// Assumes: host at 64 cycles per bit, node address 0x10 + 5
// Notes:   strobes and errors are counted by a monitor process
`timescale 1ns/1ps

module tb_top;
	import single_wire_uart_pkg::*;
	localparam int BIT = 64;
	logic        ref_clk = 1'b0;
	logic        reset, en, hostOut, dOut, dOe, chain, wrS, rdS, rxErr, nextSel;
	logic [2:0]  strap;
	logic [7:0]  base;
	logic [3:0]  turn;
	logic [7:0]  cnt, b, c, dg [8], rep [8];
	logic [6:0]  rAddr;
	logic [31:0] wData, rData;
	bit          ok;
	int          mismatches = 0, samples_checked = 0;
	int          cyc = 0, wrN = 0, rdN = 0, errN = 0, rdAt = 0, oeAt = 0;
	wire         lineLevel = dOe ? dOut : hostOut;

	always #2 ref_clk = ~ref_clk;

	single_wire_uart_slave i_dut (.ref_clk(ref_clk), .reset(reset), .clkEn(en),
		.singleWireDataPinIn(lineLevel), .singleWireDataPinOut(dOut), .singleWireDataPinOe(dOe),
		.addressStrapBit2(strap[2]), .addressStrapBit1(strap[1]), .addressStrapBit0(strap[0]),
		.nodeAddressBase(base), .replyTurnaroundDelay(turn), .nextUnitSelect(nextSel),
		.chainEnableOutput(chain), .writeStrobe(wrS), .readStrobe(rdS), .regAddr(rAddr),
		.writeData(wData), .readData(rData), .datagramCount(cnt), .rxError(rxErr));

	host_uart_model #(.BIT(BIT)) i_host (.ref_clk(ref_clk), .lineLevel(lineLevel), .hostOut(hostOut));

	// ==========================================================
	// monitor
	always @(posedge ref_clk) begin
		cyc++;
		if (wrS === 1'b1) wrN++;
		if (rdS === 1'b1) begin
			rdN++;
			rdAt = cyc;
		end
		if (rxErr === 1'b1) errN++;
	end
	always @(posedge dOe) oeAt = cyc;

	// ==========================================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic dgram(input logic [7:0] a, input logic [7:0] r, input logic [31:0] d, input int n,
		input bit bad);
		dg = '{8'h05, a, r, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
		i_host.send_dg(dg, n, bad);
		repeat (8) @(negedge ref_clk);
	endtask

	// ==========================================================
	// tests; recovery gaps give 16 idle bits, above the 12 needed
	initial begin
		// the scenarios need about 40k cycles; this leaves headroom
		#250000;
		mismatches++;
		close_out();
	end

	initial begin
		reset   = 1'b1;
		en      = 1'b1;
		nextSel = 1'b1;
		strap   = 3'h5;
		base    = 8'h10;
		turn    = 4'h2;
		rData   = 32'hc3a5_0f96;
		repeat (8) @(negedge ref_clk);
		chk("chain", 1, chain);
		chk("oe", 0, dOe);
		chk("count", 0, cnt);
		reset = 1'b0;
		nextSel = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk("chain", 0, chain);
		en = 1'b0;
		nextSel = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk("chain", 0, chain);
		en = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("chain", 1, chain);
		nextSel = 1'b0;
		dgram(8'h15, 8'h90, 32'h1234_5678, 8, 0);
		chk("writes", 1, wrN);
		chk("regAddr", 7'h10, rAddr);
		chk("writeData", 32'h1234_5678, wData);
		chk("count", 1, cnt);
		chk("oe", 0, dOe);
		dgram(8'h16, 8'h90, 32'h0, 8, 0);
		chk("writes", 1, wrN);
		chk("errors", 0, errN);
		base = 8'hff;
		strap = 3'h0;
		repeat (8) @(negedge ref_clk);
		dgram(8'hff, 8'h90, 32'h0, 8, 0);
		chk("writes", 1, wrN);
		base = 8'h10;
		strap = 3'h5;
		dgram(8'h15, 8'h91, 32'h0, 8, 1);
		chk("errors", 1, errN);
		chk("count", 1, cnt);
		i_host.bits(16);
		i_host.pulse_low(8);
		i_host.bits(16);
		chk("errors", 2, errN);
		i_host.send_byte(8'h05);
		i_host.send_byte(8'h15);
		i_host.bits(70);
		chk("errors", 3, errN);
		i_host.bits(16);
		dgram(8'h15, 8'h22, 32'h0, 4, 0);
		chk("reads", 1, rdN);
		chk("regAddr", 7'h22, rAddr);
		chk("count", 1, cnt);
		rep = '{8'h05, 8'hff, 8'h22, rData[31:24], rData[23:16], rData[15:8], rData[7:0], 8'h00};
		c = 8'h00;
		for (int i = 0; i < 7; i++) c = i_host.crc8(c, rep[i]);
		rep[7] = c;
		for (int i = 0; i < 8; i++) begin
			i_host.recv_byte(b, ok);
			chk("frame", 1, ok);
			chk("reply", rep[i], b);
		end
		chk("turnaround", 1, (oeAt - rdAt >= 24 * BIT) && (oeAt - rdAt <= 24 * BIT + 4));
		i_host.bits(4);
		chk("oe", 1, dOe);
		i_host.bits(1);
		chk("oe", 0, dOe);
		close_out();
	end
endmodule
